// ---- verilog/asw_defines.svh ----
/*
 Timing constants for the asynchronous static memory write controller.
 Assumes a core clock of 100 MHz; the slow grade is the default.
*/
`ifndef ASW_DEFINES_SVH
`define ASW_DEFINES_SVH

`define ASW_CLK_PERIOD_NS  10
// Slow grade figures in ns (fast grade: 25, 45, 40, 55)
`define ASW_DATA_OVERLAP_NS 30
`define ASW_ADDR_WRITE_NS   60
`define ASW_SEL_WRITE_NS    60
`define ASW_STROBE_LOW_NS   50
`define ASW_CYCLE_NS        70
`define ASW_FLOAT_WAIT_NS   30
`define ASW_ADDR_LEAD_NS    0
`define ASW_DATA_HOLD_NS    0
// Least times round up to whole cycles, never under one
`define ASW_CYC_UP(ns) \
   ((((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS))

`endif

// ---- verilog/asw_pkg.sv ----
/*
 Types for the asynchronous static memory write controller.
 Assumes asw_defines.svh supplies the timing constants.
*/
package asw_pkg;

   typedef enum logic [4:0] {
      ASW_IDLE   = 5'h01,
      ASW_FLOAT  = 5'h02,
      ASW_STROBE = 5'h04,
      ASW_HOLD   = 5'h08,
      ASW_TAIL   = 5'h10
   } asw_state_t;

endpackage : asw_pkg

// ---- verilog/asw_ctrl.sv ----
/*
 Host-side write controller for an asynchronous 128K x 8 static memory.
 Assumes the memory pins are driven straight from these flip-flops and
 that the board adds no more delay than one core clock period.
*/
// Notes on behaviour
// (RULE1) Memory writes only while both selects active and strobe low.
// (RULE2) Any of the three signals going inactive ends the write.
// (RULE3) Data setup and hold are timed to the terminating edge.
// (RULE4) Data valid at least 25/30 ns before the write ends.
// (RULE5) Data held at least 0 ns after the write ends.
// (RULE6) Address stable at least 45/60 ns before the write ends.
// (RULE7) Address valid no later than the write starts.
// (RULE8) Address unchanged until the earliest terminating edge.
// (RULE9) Memory floats its outputs within 20 ns of strobe low.
// (RULE10) Memory re-drives no sooner than 5 ns after write end.
// (RULE11) Memory floats within 30 ns of output gate going inactive.
// (RULE12) Selected with or after strobe fall, outputs stay floating.
// (RULE13) Controller never fights memory output; drives after release.
// (RULE14) With gate low, memory shows just-written data after write.
// (RULE15) New address with gate low shows that address's contents.
// (RULE16) Select-to-end time counts from the later select activation.
// (RULE17) Both selects active at least 45/60 ns before write end.
// (RULE18) Either select inactive deselects and floats the memory.
// (RULE19) Selected with strobe low stores data whatever the gate.
// (RULE20) Both selects needed for any access at all.
// (RULE21) Strobe held low at least 40/50 ns.
// (RULE22) Each write cycle lasts at least the minimum cycle time.
`timescale 1ns/100ps
`include "asw_defines.svh"

module asw_ctrl
   import asw_pkg::*;
#(
   parameter int ADDR_W = 17,
   parameter int DATA_W = 8
)(
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              wr_req,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   output logic                   wr_busy,
   output logic                   wr_done,
   output logic [ADDR_W-1:0]      word_select_lines,
   output logic                   select_low_active_n,
   output logic                   select_high_active,
   output logic                   write_strobe_n,
   output logic                   output_gate_n,
   output logic [DATA_W-1:0]      data_lines_out,
   output logic                   data_lines_oe
);

   // Cycle counts derived from the timing figures
   localparam int FLOAT_CYC  = `ASW_CYC_UP(`ASW_FLOAT_WAIT_NS);
   localparam int DATA_CYC   = `ASW_CYC_UP(`ASW_DATA_OVERLAP_NS);
   localparam int ADDR_CYC   = `ASW_CYC_UP(`ASW_ADDR_WRITE_NS);
   localparam int SEL_CYC    = `ASW_CYC_UP(`ASW_SEL_WRITE_NS);
   localparam int STROBE_CYC = `ASW_CYC_UP(`ASW_STROBE_LOW_NS);
   localparam int CYCLE_CYC  = `ASW_CYC_UP(`ASW_CYCLE_NS);
   localparam int LEAD_CYC   = `ASW_CYC_UP(`ASW_ADDR_LEAD_NS);
   localparam int HOLD_CYC   = `ASW_CYC_UP(`ASW_DATA_HOLD_NS);

   // Longest of the four pulse needs decides the strobe low time
   function automatic int max3(input int a, input int b, input int c);
      int m;
      m = (a > b) ? a : b;
      max3 = (m > c) ? m : c;
   endfunction : max3

   localparam int LOW_CYC  = max3(ADDR_CYC, SEL_CYC,
                                  max3(STROBE_CYC, DATA_CYC, 1));
   localparam int PRE_CYC  = LEAD_CYC + FLOAT_CYC;
   localparam int USED_CYC = PRE_CYC + LOW_CYC + HOLD_CYC;
   localparam int TAIL_CYC = (CYCLE_CYC > USED_CYC) ?
                             CYCLE_CYC - USED_CYC : 1;
   // Counters load one less, since the zero cycle also counts
   localparam logic [7:0] PRE_CNT  = 8'(PRE_CYC - 1);
   localparam logic [7:0] LOW_CNT  = 8'(LOW_CYC - 1);
   localparam logic [7:0] HOLD_CNT = 8'(HOLD_CYC - 1);
   localparam logic [7:0] TAIL_CNT = 8'(TAIL_CYC - 1);

   typedef struct packed {
      asw_state_t        st;
      logic [7:0]        cnt;
      logic              busy;
      logic              done;
      logic [ADDR_W-1:0] addr;
      logic              sel_n;
      logic              sel;
      logic              we_n;
      logic              oe_n;
      logic [DATA_W-1:0] dout;
      logic              dq_oe;
   } asw_regs_t;

   asw_regs_t cur_r;
   asw_regs_t cur_nxt;

   // Write sequencer: float, strobe, hold, then pad out the cycle
   always_comb
   begin
      cur_nxt      = cur_r;
      cur_nxt.done = 1'b0;
      case (cur_r.st)
         ASW_IDLE:
         begin
            if (wr_req)
            begin
               // (RULE7) address before start
               cur_nxt.addr  = wr_addr;
               cur_nxt.dout  = wr_data;
               // (RULE16) selects first, strobe later
               cur_nxt.sel_n = 1'b0;
               cur_nxt.sel   = 1'b1;
               // (RULE13) gate off, memory releases
               cur_nxt.oe_n  = 1'b1;
               cur_nxt.busy  = 1'b1;
               cur_nxt.cnt   = PRE_CNT;
               cur_nxt.st    = ASW_FLOAT;
            end
         end
         ASW_FLOAT:
         begin
            // Gate high since accept, so the memory has floated
            if (cur_r.cnt == 8'h00)
            begin
               // (RULE1) strobe opens write window
               cur_nxt.we_n  = 1'b0;
               // (RULE13) drive only after release
               cur_nxt.dq_oe = 1'b1;
               cur_nxt.cnt   = LOW_CNT;
               cur_nxt.st    = ASW_STROBE;
            end
            else
               cur_nxt.cnt = cur_r.cnt - 8'h01;
         end
         ASW_STROBE:
         begin
            // (RULE4) data, address, select, pulse width
            // (RULE6) address stable all pulse long
            // (RULE17) selects held through pulse
            // (RULE21) strobe low long enough
            if (cur_r.cnt == 8'h00)
            begin
               // (RULE2) strobe rise terminates write
               // (RULE3) strobe is the terminating edge
               cur_nxt.we_n = 1'b1;
               cur_nxt.cnt  = HOLD_CNT;
               cur_nxt.st   = ASW_HOLD;
            end
            else
               cur_nxt.cnt = cur_r.cnt - 8'h01;
         end
         ASW_HOLD:
         begin
            if (cur_r.cnt == 8'h00)
            begin
               // (RULE5) data released after end
               cur_nxt.dq_oe = 1'b0;
               // (RULE8) selects drop after strobe
               cur_nxt.sel_n = 1'b1;
               cur_nxt.sel   = 1'b0;
               cur_nxt.cnt   = TAIL_CNT;
               cur_nxt.st    = ASW_TAIL;
            end
            else
               cur_nxt.cnt = cur_r.cnt - 8'h01;
         end
         ASW_TAIL:
         begin
            // (RULE22) pad to minimum cycle time
            // Done cycle is idle already; a held request goes next edge
            if (cur_r.cnt == 8'h00)
            begin
               cur_nxt.busy = 1'b0;
               cur_nxt.done = 1'b1;
               cur_nxt.st   = ASW_IDLE;
            end
            else
               cur_nxt.cnt = cur_r.cnt - 8'h01;
         end
         default:
            cur_nxt.st = ASW_IDLE;
      endcase
   end

   // State register; memory idle and deselected after reset
   // Async clear lifts strobe and selects at once, cutting any write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_r.st    <= ASW_IDLE;
         cur_r.cnt   <= 8'h00;
         cur_r.busy  <= 1'b0;
         cur_r.done  <= 1'b0;
         cur_r.addr  <= '0;
         cur_r.sel_n <= 1'b1;
         cur_r.sel   <= 1'b0;
         cur_r.we_n  <= 1'b1;
         cur_r.oe_n  <= 1'b1;
         cur_r.dout  <= '0;
         cur_r.dq_oe <= 1'b0;
      end
      else
         cur_r <= cur_nxt;
   end

   // Pins come straight from the state flip-flops
   // No gating after the flops, so the memory never sees glitches
   assign wr_busy             = cur_r.busy;
   assign wr_done             = cur_r.done;
   assign word_select_lines   = cur_r.addr;
   assign select_low_active_n = cur_r.sel_n;
   assign select_high_active  = cur_r.sel;
   assign write_strobe_n      = cur_r.we_n;
   assign output_gate_n       = cur_r.oe_n;
   assign data_lines_out      = cur_r.dout;
   assign data_lines_oe       = cur_r.dq_oe;

endmodule : asw_ctrl

// ---- sim/asw_ctrl_checker.sv ----
/*
 Pin timing checker for the write controller.
 Assumes a bind into asw_ctrl on a 100 MHz core_clk.
*/
`timescale 1ns/100ps
module asw_ctrl_checker #(
   parameter int ADDR_W = 17,
   parameter int DATA_W = 8
)(
   input wire logic              core_clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] word_select_lines,
   input wire logic              select_low_active_n,
   input wire logic              select_high_active,
   input wire logic              write_strobe_n,
   input wire logic              output_gate_n,
   input wire logic [DATA_W-1:0] data_lines_out,
   input wire logic              data_lines_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Strobe edges open and close a write
   sequence s_beg; $fell(write_strobe_n); endsequence
   sequence s_end; $rose(write_strobe_n); endsequence
   property p_dovl;
      s_beg |-> (data_lines_oe && $stable(data_lines_out))[*3];
   endproperty
   a_dovl: assert property (p_dovl) else $error("data overlap");
   // Data window measured back from the terminating edge
   property p_dsetup;
      s_end |-> $past(data_lines_oe, 3) && $stable(data_lines_out)
         && $past(data_lines_out, 3) == data_lines_out;
   endproperty
   a_dsetup: assert property (p_dsetup) else $error("data setup");
   property p_dhold;
      s_end |-> data_lines_oe && $stable(data_lines_out);
   endproperty
   a_dhold: assert property (p_dhold) else $error("data hold");
   property p_addr;
      s_end |-> $past(word_select_lines, 6) == word_select_lines
         && $stable(word_select_lines);
   endproperty
   a_addr: assert property (p_addr) else $error("address");
   property p_lead;
      s_beg |-> $stable(word_select_lines) && !select_low_active_n;
   endproperty
   a_lead: assert property (p_lead) else $error("address lead");
   property p_sel;
      s_end |-> select_high_active && $past(select_high_active, 6)
         && $past(select_low_active_n, 6) == 1'b0;
   endproperty
   a_sel: assert property (p_sel) else $error("select time");
   property p_pulse;
      s_beg |-> !write_strobe_n[*5];
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe width");
   property p_fight;
      data_lines_oe |-> output_gate_n && $past(output_gate_n, 3);
   endproperty
   a_fight: assert property (p_fight) else $error("bus fight");
   property p_cyc;
      $changed(word_select_lines) |=> $stable(word_select_lines)[*6];
   endproperty
   a_cyc: assert property (p_cyc) else $error("cycle time");
endmodule : asw_ctrl_checker

bind asw_ctrl asw_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
   .core_clk, .rst_n, .word_select_lines, .select_low_active_n,
   .select_high_active, .write_strobe_n, .output_gate_n,
   .data_lines_out, .data_lines_oe);

// ---- sim/asw_mem_model.sv ----
/*
 Behavioural model of the 128K x 8 static memory.
 Assumes the bench resolves the shared data lines.
*/
`timescale 1ns/100ps
module asw_mem_model (
   input wire logic [16:0] word_select_lines,
   input wire logic        select_low_active_n,
   input wire logic        select_high_active,
   input wire logic        write_strobe_n,
   input wire logic        output_gate_n,
   input wire logic [7:0]  data_lines,
   output logic [7:0]      mem_q,
   output logic            mem_oe
);
   logic [7:0] mem [0:131071];
   logic       sel;
   assign sel = !select_low_active_n && select_high_active;
   always @*
      if (sel && !write_strobe_n)
         mem[word_select_lines] = data_lines;
   // late drive, gate ignored in write
   assign #5 mem_oe = sel && write_strobe_n && !output_gate_n;
   always @*
      mem_q = mem[word_select_lines];
endmodule : asw_mem_model

// ---- sim/test_async_sram_write_cycle.sv ----
/*
 Self-checking bench for asw_ctrl with the memory model.
 Assumes a 100 MHz core_clk; inputs move 1 ns after edges.
*/
`timescale 1ns/100ps
module test_async_sram_write_cycle;
   logic        core_clk = 0;
   logic        rst_n = 0;
   logic        wr_req = 0;
   logic [16:0] wr_addr = 0;
   logic [7:0]  wr_data = 0;
   logic        wr_busy, wr_done, select_low_active_n, select_high_active;
   logic        write_strobe_n, output_gate_n, data_lines_oe, mem_oe;
   logic [16:0] word_select_lines;
   logic [7:0]  data_lines_out, mem_q, dq_last = 0;
   wire  [7:0]  data_lines;
   int          error_cnt = 0, cmp_count = 0, cyc = 0;
   // Released lines show the inverse, never a stale match
   assign data_lines = data_lines_oe ? data_lines_out :
                       (mem_oe ? mem_q : ~dq_last);
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (data_lines_oe) dq_last <= data_lines_out;
   asw_ctrl dut_u (.core_clk, .rst_n, .wr_req, .wr_addr, .wr_data,
      .wr_busy, .wr_done, .word_select_lines, .select_low_active_n,
      .select_high_active, .write_strobe_n, .output_gate_n,
      .data_lines_out, .data_lines_oe);
   asw_mem_model mdl_u (.word_select_lines, .select_low_active_n,
      .select_high_active, .write_strobe_n, .output_gate_n,
      .data_lines, .mem_q, .mem_oe);
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // Idle pins: busy, done, selects, strobe, gate, enable
   task automatic chk_idle;
      chk("pins", 8'h58, {1'b0, select_low_active_n, select_high_active,
         write_strobe_n, output_gate_n, data_lines_oe, wr_busy, wr_done});
   endtask : chk_idle
   // Bounded wait; always steps one edge first
   task automatic wait_done;
      int i = 0;
      do @(posedge core_clk) #1; while (wr_done !== 1'b1 && ++i < 30);
      chk("wr_done", 8'h01, {7'h0, wr_done});
   endtask : wait_done
   // Accept to done is twelve edges; done stands one cycle
   task automatic wr(input logic [16:0] a, input logic [7:0] d);
      int t0;
      @(posedge core_clk) #1;
      {wr_req, wr_addr, wr_data} = {1'b1, a, d};
      @(posedge core_clk) #1;
      wr_req = 0;
      t0 = cyc;
      wait_done();
      chk("latency", 8'h0c, 8'(cyc - t0));
      chk("stored", d, mdl_u.mem[a]);
      @(posedge core_clk) #1;
      chk("done pulse", 8'h00, {7'h0, wr_done});
   endtask : wr
   // Request held high: next taken in the done cycle
   task automatic t_b2b;
      @(posedge core_clk) #1;
      {wr_req, wr_addr, wr_data} = {1'b1, 17'h1ffff, 8'hff};
      wait_done();
      {wr_addr, wr_data} = {17'h00000, 8'h00};
      @(posedge core_clk) #1;
      wr_req = 0;
      wait_done();
      chk("top", 8'hff, mdl_u.mem[17'h1ffff]);
      chk("base", 8'h00, mdl_u.mem[0]);
   endtask : t_b2b
   // Changes while busy must not leak into the memory
   task automatic t_refuse;
      mdl_u.mem[17'h000c3] = 8'h3c;
      @(posedge core_clk) #1;
      {wr_req, wr_addr, wr_data} = {1'b1, 17'h000a5, 8'h5a};
      @(posedge core_clk) #1;
      {wr_addr, wr_data} = {17'h000c3, 8'hc3};
      chk("wr_busy", 8'h01, {7'h0, wr_busy});
      repeat (3) @(posedge core_clk);
      #1 wr_req = 0;
      wait_done();
      chk("taken", 8'h5a, mdl_u.mem[17'h000a5]);
      chk("ignored", 8'h3c, mdl_u.mem[17'h000c3]);
   endtask : t_refuse
   // Reset inside a strobe pulse, then a clean write
   task automatic t_mid_rst;
      @(posedge core_clk) #1;
      {wr_req, wr_addr, wr_data} = {1'b1, 17'h00001, 8'h81};
      repeat (6) @(posedge core_clk);
      #1 rst_n = 0;
      wr_req = 0;
      #1 chk_idle();
      @(posedge core_clk) #1 rst_n = 1;
      wr(17'h00002, 8'h24);
   endtask : t_mid_rst
   // Cycle ceiling against a hung handshake
   always @(posedge core_clk)
      if (++cyc == 2000)
      begin
         error_cnt++;
         end_sim();
      end
   initial
   begin
      repeat (6) @(posedge core_clk);
      #1 rst_n = 1;
      chk_idle();
      t_b2b();
      t_refuse();
      t_mid_rst();
      end_sim();
   end
endmodule : test_async_sram_write_cycle
